// ===== rct_map.svh
// register indexes, field positions and reset values of the reload/compare timer
// Behaviour
// - overflow/match flag, control bit 7, sets on counter wrap or compare match
// - flag stays set until software writes it to zero, never auto-cleared
// - interrupt requested while flag, timer enable and global enable are all set
// - run bit 2 low stops prescaler ticks to both count bytes (captures still reload or clear), high lets counting proceed
// - control bit 0 picks mode: zero auto-reload, one compare
// - reload into counter happens only while reload enable, mode bit 7, is one
// - prescale select gives 1/1, 1/4, 1/16, 1/32, 1/64, 1/128, 1/256, 1/512
// - capture event copies current count bytes into the reload/compare pair
// - auto-reload mode with capture clear set zeroes counter after capture
// - compare mode with match clear set zeroes counter after a match
// - reload trigger: 00 overflow, 01/10/11 capture channel 0/1/2
// - compare mode compares counter against the reload/compare pair
// - auto-reload mode loads the reload/compare pair into the counter
// - two count bytes form one 16-bit up-counter, each byte software accessible
// - control, low reload/compare byte and low count byte reset to zero
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// register indexes; byte address is four times the index
`define RCT_IDX_CTRL    8'hc8
`define RCT_IDX_MODE    8'hc9
`define RCT_IDX_RCMPL   8'hca
`define RCT_IDX_RCMPH   8'hcb
`define RCT_IDX_CNTL    8'hcc
`define RCT_IDX_CNTH    8'hcd
`define RCT_IDX_ISTAT   8'hd0
`define RCT_IDX_IMASK   8'hd1

// field positions
`define RCT_CTRL_FLAG   7
`define RCT_CTRL_RUN    2
`define RCT_CTRL_CMP    0
`define RCT_ST_CAP      0
`define RCT_ST_RELOAD   1
`define RCT_MSK_TIMER   0
`define RCT_MSK_CAP     1
`define RCT_MSK_RELOAD  2
`define RCT_MSK_GLOBAL  7

// reset values
`define RCT_CTRL_RST    8'h00
`define RCT_MODE_RST    8'h00
`define RCT_BYTE_RST    8'h00
`define RCT_IRQ_RST     8'h00

// bus answers
`define RCT_RESP_OKAY   2'h0
`define RCT_RESP_SLVERR 2'h2

`endif

// ===== rct_pkg.sv
// types shared by the reload/compare timer
package rct_pkg;

   // control register layout
   typedef struct packed {
      logic       flag;
      logic [3:0] rsv_hi;
      logic       run;
      logic       rsv_lo;
      logic       cmp_mode;
   } rct_ctrl_t;

   // mode register layout
   typedef struct packed {
      logic       reload_enable;
      logic [2:0] prescale_select;
      logic       capture_clear_enable;
      logic       match_clear_enable;
      logic [1:0] reload_trigger_select;
   } rct_mode_t;

   typedef enum logic {RCT_WR_COLLECT, RCT_WR_RESP} rct_wr_state_t;
   typedef enum logic {RCT_RD_IDLE, RCT_RD_RESP} rct_rd_state_t;

endpackage : rct_pkg

// ===== rct_timer.sv
// reload/compare timer with AXI4-Lite register slave and interrupt output
`include "rct_map.svh"

module rct_timer #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,          // system clock, 250 MHz
   input  wire logic              aresetn,       // synchronous reset, active low
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // write byte enables
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready,  // read data ready
   input  wire logic [2:0]        cap_event,     // capture pulses, same clock
   output logic                   irq            // level interrupt request
);

   // the word index must hold an 8-bit register index
   if (ADDR_W < 10) begin : g_addr_check
      $error("rct_timer: ADDR_W must be at least 10");
   end

   rct_pkg::rct_ctrl_t     ctrl_ff;
   rct_pkg::rct_mode_t     mode_ff;
   rct_pkg::rct_wr_state_t wr_state_ff;
   rct_pkg::rct_rd_state_t rd_state_ff;
   logic [15:0]            cnt_ff;
   logic [15:0]            rcmp_ff;
   logic [8:0]             presc_ff;
   logic [7:0]             istat_ff;
   logic [7:0]             imask_ff;
   logic                   irq_ff;
   logic                   aw_held_ff;
   logic                   w_held_ff;
   logic [ADDR_W-1:0]      aw_addr_ff;
   logic [7:0]             w_byte_ff;
   logic                   w_lane_ff;
   logic                   awready_ff;
   logic                   wready_ff;
   logic                   bvalid_ff;
   logic [1:0]             bresp_ff;
   logic                   arready_ff;
   logic                   rvalid_ff;
   logic [1:0]             rresp_ff;
   logic [31:0]            rdata_ff;

   // word index match against a register index
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
   endfunction : reg_hit

   // last prescaler count for each divide setting
   function automatic logic [8:0] div_last(input logic [2:0] sel);
      case (sel)
         3'h0:    return 9'h000;
         3'h1:    return 9'h003;
         3'h2:    return 9'h00f;
         3'h3:    return 9'h01f;
         3'h4:    return 9'h03f;
         3'h5:    return 9'h07f;
         3'h6:    return 9'h0ff;
         default: return 9'h1ff;
      endcase
   endfunction : div_last

   // known register at this address
   function automatic logic reg_known(input logic [ADDR_W-1:0] a);
      return reg_hit(a, `RCT_IDX_CTRL) | reg_hit(a, `RCT_IDX_MODE) |
             reg_hit(a, `RCT_IDX_RCMPL) | reg_hit(a, `RCT_IDX_RCMPH) |
             reg_hit(a, `RCT_IDX_CNTL) | reg_hit(a, `RCT_IDX_CNTH) |
             reg_hit(a, `RCT_IDX_ISTAT) | reg_hit(a, `RCT_IDX_IMASK);
   endfunction : reg_known

   // ---------------------------------------------------------------- write decode
   logic wr_fire;
   logic wr_en;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_rcmpl;
   logic wr_rcmph;
   logic wr_cntl;
   logic wr_cnth;
   logic wr_istat;
   logic wr_imask;

   // a register write happens once both halves are held; byte lane 0 carries it
   assign wr_fire  = aw_held_ff & w_held_ff & (wr_state_ff == rct_pkg::RCT_WR_COLLECT);
   assign wr_en    = wr_fire & w_lane_ff;
   assign wr_ctrl  = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_CTRL);
   assign wr_mode  = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_MODE);
   assign wr_rcmpl = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_RCMPL);
   assign wr_rcmph = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_RCMPH);
   assign wr_cntl  = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_CNTL);
   assign wr_cnth  = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_CNTH);
   assign wr_istat = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_ISTAT);
   assign wr_imask = wr_en & reg_hit(aw_addr_ff, `RCT_IDX_IMASK);

   // ---------------------------------------------------------------- timer events
   logic tick;
   logic is_ovf;
   logic is_match;
   logic cap_any;
   logic trig_hit;
   logic do_reload;
   logic cnt_wr;

   // prescaler wraps at the selected divide; 000 ticks every cycle
   assign tick     = ctrl_ff.run & (presc_ff == div_last(mode_ff.prescale_select));
   assign is_ovf   = tick & (cnt_ff == 16'hffff);
   assign is_match = tick & ctrl_ff.cmp_mode & (cnt_ff == rcmp_ff);
   assign cap_any  = |cap_event;
   assign cnt_wr   = wr_cntl | wr_cnth;

   // reload source: overflow or one capture channel
   always_comb begin
      case (mode_ff.reload_trigger_select)
         2'h0:    trig_hit = is_ovf;
         2'h1:    trig_hit = cap_event[0];
         2'h2:    trig_hit = cap_event[1];
         default: trig_hit = cap_event[2];
      endcase
   end

   // reload only in auto-reload mode and only while enabled
   assign do_reload = ~ctrl_ff.cmp_mode & mode_ff.reload_enable & trig_hit;

   // prescaler, held at zero while stopped so a restart begins a full period
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_ff.run) begin
         presc_ff <= 9'h000;
      end else if (tick) begin
         presc_ff <= 9'h000;
      end else begin
         presc_ff <= presc_ff + 9'h001;
      end
   end

   // 16-bit counter; software byte writes win over any hardware event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= {8'h00, `RCT_BYTE_RST};
      end else if (cnt_wr) begin
         if (wr_cntl) begin
            cnt_ff[7:0] <= w_byte_ff;
         end
         if (wr_cnth) begin
            cnt_ff[15:8] <= w_byte_ff;
         end
      end else if (do_reload) begin
         cnt_ff <= rcmp_ff;
      end else if (cap_any && !ctrl_ff.cmp_mode && mode_ff.capture_clear_enable) begin
         cnt_ff <= 16'h0000;
      end else if (is_match && mode_ff.match_clear_enable) begin
         cnt_ff <= 16'h0000;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // reload/compare pair; capture copies the count as it stood before this edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcmp_ff <= {8'h00, `RCT_BYTE_RST};
      end else if (wr_rcmpl || wr_rcmph) begin
         if (wr_rcmpl) begin
            rcmp_ff[7:0] <= w_byte_ff;
         end
         if (wr_rcmph) begin
            rcmp_ff[15:8] <= w_byte_ff;
         end
      end else if (cap_any) begin
         rcmp_ff <= cnt_ff;
      end
   end

   // control and mode; flag sets beat a software clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `RCT_CTRL_RST;
         mode_ff <= `RCT_MODE_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff.run      <= w_byte_ff[`RCT_CTRL_RUN];
            ctrl_ff.cmp_mode <= w_byte_ff[`RCT_CTRL_CMP];
         end
         if (is_ovf || is_match) begin
            ctrl_ff.flag <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl_ff.flag <= w_byte_ff[`RCT_CTRL_FLAG];
         end
         if (wr_mode) begin
            mode_ff <= w_byte_ff;
         end
      end
   end

   // sticky capture and reload status, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_ff <= `RCT_IRQ_RST;
         imask_ff <= `RCT_IRQ_RST;
      end else begin
         if (cap_any) begin
            istat_ff[`RCT_ST_CAP] <= 1'b1;
         end else if (wr_istat && w_byte_ff[`RCT_ST_CAP]) begin
            istat_ff[`RCT_ST_CAP] <= 1'b0;
         end
         if (do_reload) begin
            istat_ff[`RCT_ST_RELOAD] <= 1'b1;
         end else if (wr_istat && w_byte_ff[`RCT_ST_RELOAD]) begin
            istat_ff[`RCT_ST_RELOAD] <= 1'b0;
         end
         if (wr_imask) begin
            imask_ff <= w_byte_ff;
         end
      end
   end

   // interrupt level, one cycle behind the bits that raise it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= imask_ff[`RCT_MSK_GLOBAL] &
                   ((ctrl_ff.flag & imask_ff[`RCT_MSK_TIMER]) |
                    (istat_ff[`RCT_ST_CAP] & imask_ff[`RCT_MSK_CAP]) |
                    (istat_ff[`RCT_ST_RELOAD] & imask_ff[`RCT_MSK_RELOAD]));
      end
   end

   // ---------------------------------------------------------------- write channel
   // address and data are taken in either order; ready drops until the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_ff <= rct_pkg::RCT_WR_COLLECT;
         aw_held_ff  <= 1'b0;
         w_held_ff   <= 1'b0;
         aw_addr_ff  <= '0;
         w_byte_ff   <= 8'h00;
         w_lane_ff   <= 1'b0;
         awready_ff  <= 1'b1;
         wready_ff   <= 1'b1;
         bvalid_ff   <= 1'b0;
         bresp_ff    <= `RCT_RESP_OKAY;
      end else begin
         case (wr_state_ff)
            rct_pkg::RCT_WR_COLLECT: begin
               if (s_axi_awvalid && awready_ff) begin
                  aw_held_ff <= 1'b1;
                  aw_addr_ff <= s_axi_awaddr;
                  awready_ff <= 1'b0;
               end
               if (s_axi_wvalid && wready_ff) begin
                  w_held_ff <= 1'b1;
                  w_byte_ff <= s_axi_wdata[7:0];
                  w_lane_ff <= s_axi_wstrb[0];
                  wready_ff <= 1'b0;
               end
               if (wr_fire) begin
                  aw_held_ff  <= 1'b0;
                  w_held_ff   <= 1'b0;
                  bvalid_ff   <= 1'b1;
                  bresp_ff    <= reg_known(aw_addr_ff) ? `RCT_RESP_OKAY : `RCT_RESP_SLVERR;
                  wr_state_ff <= rct_pkg::RCT_WR_RESP;
               end
            end
            rct_pkg::RCT_WR_RESP: begin
               if (s_axi_bready) begin
                  bvalid_ff   <= 1'b0;
                  awready_ff  <= 1'b1;
                  wready_ff   <= 1'b1;
                  wr_state_ff <= rct_pkg::RCT_WR_COLLECT;
               end
            end
            default: wr_state_ff <= rct_pkg::RCT_WR_COLLECT;
         endcase
      end
   end

   // ---------------------------------------------------------------- read channel
   logic [7:0] rd_byte;

   // read mux; reserved control bits read zero
   always_comb begin
      rd_byte = 8'h00;
      if (reg_hit(s_axi_araddr, `RCT_IDX_CTRL)) begin
         rd_byte = {ctrl_ff.flag, 4'h0, ctrl_ff.run, 1'b0, ctrl_ff.cmp_mode};
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_MODE)) begin
         rd_byte = mode_ff;
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_RCMPL)) begin
         rd_byte = rcmp_ff[7:0];
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_RCMPH)) begin
         rd_byte = rcmp_ff[15:8];
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_CNTL)) begin
         rd_byte = cnt_ff[7:0];
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_CNTH)) begin
         rd_byte = cnt_ff[15:8];
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_ISTAT)) begin
         rd_byte = istat_ff;
      end else if (reg_hit(s_axi_araddr, `RCT_IDX_IMASK)) begin
         rd_byte = imask_ff;
      end
   end

   // one read in flight; data answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_ff <= rct_pkg::RCT_RD_IDLE;
         arready_ff  <= 1'b1;
         rvalid_ff   <= 1'b0;
         rresp_ff    <= `RCT_RESP_OKAY;
         rdata_ff    <= 32'h0000_0000;
      end else begin
         case (rd_state_ff)
            rct_pkg::RCT_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  arready_ff  <= 1'b0;
                  rvalid_ff   <= 1'b1;
                  rdata_ff    <= {24'h00_0000, rd_byte};
                  rresp_ff    <= reg_known(s_axi_araddr) ? `RCT_RESP_OKAY : `RCT_RESP_SLVERR;
                  rd_state_ff <= rct_pkg::RCT_RD_RESP;
               end
            end
            rct_pkg::RCT_RD_RESP: begin
               if (s_axi_rready) begin
                  rvalid_ff   <= 1'b0;
                  arready_ff  <= 1'b1;
                  rd_state_ff <= rct_pkg::RCT_RD_IDLE;
               end
            end
            default: rd_state_ff <= rct_pkg::RCT_RD_IDLE;
         endcase
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign irq           = irq_ff;

   // ---------------------------------------------------------------- checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_flag_set;
      (is_ovf || is_match) |=> ctrl_ff.flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

   property p_flag_sticky;
      ctrl_ff.flag && !wr_ctrl |=> ctrl_ff.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared itself");

   property p_irq_level;
      ctrl_ff.flag && imask_ff[`RCT_MSK_TIMER] && imask_ff[`RCT_MSK_GLOBAL] |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq missing");

   property p_stopped;
      !ctrl_ff.run && !cnt_wr && !do_reload && !cap_any |=> $stable(cnt_ff);
   endproperty
   a_stopped: assert property (p_stopped) else $error("count moved while stopped");

   property p_no_reload_cmp;
      ctrl_ff.cmp_mode && !cnt_wr && !cap_any && !is_match && !tick |=> $stable(cnt_ff);
   endproperty
   a_no_reload_cmp: assert property (p_no_reload_cmp) else $error("reload in compare mode");

   property p_reload_gate;
      !mode_ff.reload_enable && !cnt_wr && !cap_any && !tick |=> $stable(cnt_ff);
   endproperty
   a_reload_gate: assert property (p_reload_gate) else $error("reload while disabled");

   property p_div_one;
      ctrl_ff.run && mode_ff.prescale_select == 3'h0 |-> tick;
   endproperty
   a_div_one: assert property (p_div_one) else $error("divide by one missed tick");

   property p_div_gap;
      tick && mode_ff.prescale_select != 3'h0 && $stable(mode_ff) |=> !tick [*3];
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("prescaled tick too soon");

   property p_capture;
      cap_any && !wr_rcmpl && !wr_rcmph |=> rcmp_ff == $past(cnt_ff);
   endproperty
   a_capture: assert property (p_capture) else $error("capture lost");

   property p_cap_clear;
      cap_any && !ctrl_ff.cmp_mode && mode_ff.capture_clear_enable && !cnt_wr && !do_reload
      |=> cnt_ff == 16'h0000;
   endproperty
   a_cap_clear: assert property (p_cap_clear) else $error("capture clear failed");

   property p_match_clear;
      is_match && mode_ff.match_clear_enable && !cnt_wr |=> cnt_ff == 16'h0000;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match clear failed");

   property p_trig_cap0;
      cap_event[0] && mode_ff.reload_trigger_select == 2'h1 && mode_ff.reload_enable &&
      !ctrl_ff.cmp_mode && !cnt_wr |=> cnt_ff == $past(rcmp_ff);
   endproperty
   a_trig_cap0: assert property (p_trig_cap0) else $error("capture 0 reload missed");

   property p_step;
      tick && !cnt_wr && !do_reload && !cap_any && !is_match |=> cnt_ff == $past(cnt_ff) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("count did not step");

   property p_reset_vals;
      $rose(aresetn) |-> ctrl_ff == 8'h00 && rcmp_ff[7:0] == 8'h00 && cnt_ff[7:0] == 8'h00;
   endproperty
   a_reset_vals: assert property (@(posedge aclk) p_reset_vals) else $error("bad reset value");

   property p_wrap_reload;
      is_ovf && do_reload && !cnt_wr |=> cnt_ff == $past(rcmp_ff);
   endproperty
   a_wrap_reload: assert property (p_wrap_reload) else $error("overflow reload wrong");

   c_overflow: cover property (is_ovf && do_reload);
   c_match:    cover property (is_match && mode_ff.match_clear_enable);
   c_capture:  cover property (cap_any && mode_ff.capture_clear_enable);
   c_irq:      cover property ($rose(irq));

endmodule : rct_timer

// ===== tb.sv
// self-checking bench of the reload/compare timer
`include "rct_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CT = `RCT_IDX_CTRL, MD = `RCT_IDX_MODE, RL = `RCT_IDX_RCMPL;
   localparam logic [7:0] CL = `RCT_IDX_CNTL, IS = `RCT_IDX_ISTAT, IM = `RCT_IDX_IMASK;
   logic        aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic [2:0]  cap_event = 0;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int          errors = 0, compares = 0, seed = 14874, cyc = 0;
   logic [7:0]  d;
   logic [1:0]  rs;
   logic [15:0] w16, rv, cv;

   rct_timer u_rct_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cap_event, .irq);

   always #2 aclk = ~aclk;

   // hang guard, well above the longest prescaler run
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         wrap_up();
      end
   end

   // divider per prescale code
   function automatic int dv(input int p);
      return p == 0 ? 1 : (p == 1 ? 4 : 1 << (p + 2));
   endfunction : dv

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      @(posedge aclk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // byte pairs: low at idx, high at idx+1, no latching, so only read while stopped
   task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
      wr(idx, v[7:0]);
      wr(idx + 8'h01, v[15:8]);
   endtask : wr16

   task automatic rd16(input logic [7:0] idx);
      rd(idx);
      w16[7:0] = d;
      rd(idx + 8'h01);
      w16[15:8] = d;
   endtask : rd16

   task automatic pulse(input int ch);
      @(posedge aclk);
      cap_event <= 3'(1 << ch);
      @(posedge aclk);
      cap_event <= 3'h0;
   endtask : pulse

   // run with run bit high for n cycles plus 4 cycles of write latency, then stop
   task automatic run_for(input logic [7:0] c, input int n);
      wr(CT, c);
      repeat (n) @(posedge aclk);
      wr(CT, c & 8'hfb);
   endtask : run_for

   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CT); `CHK("ctrl reset", 8'h00, d)
      rd(RL); `CHK("rcmp low reset", 8'h00, d)
      rd(CL); `CHK("count low reset", 8'h00, d)
      rd(8'h10); `CHK("unmapped read", `RCT_RESP_SLVERR, rs)
      wr(8'h10, 8'h5a); `CHK("unmapped write", `RCT_RESP_SLVERR, rs)
      // stopped counter keeps a random value in both bytes
      cv = 16'($random(seed));
      wr16(CL, cv);
      repeat (50) @(posedge aclk);
      rd16(CL); `CHK("frozen count", cv, w16)
      // each prescale code: 4.5 periods of run time must give four ticks
      for (int p = 0; p < 8; p++) begin
         wr(MD, {1'b0, 3'(p), 4'h0});
         wr16(CL, 16'h0000);
         run_for(8'h04, dv(p) * 9 / 2 - 4);
         rd16(CL); `CHK("prescaled count", 16'(9 * dv(p) / 2 / dv(p)), w16)
      end
      // compare mode with match clear, then flag holds and drives irq
      wr(IM, 8'h81);
      wr(MD, 8'h04);
      wr16(RL, 16'h0010);
      wr16(CL, 16'h0000);
      // flag bit stays zero in the start write so only a match can raise it
      wr(CT, 8'h05);
      repeat (60) @(posedge aclk);
      `CHK("irq on match", 1'b1, irq)
      rd(CT); `CHK("match flag", 1'b1, d[7])
      wr(CT, 8'h81);
      rd16(CL); `CHK("cleared at match", 1'b1, w16 <= 16'h0010)
      wr(IM, 8'h01);
      repeat (3) @(posedge aclk);
      `CHK("irq without global", 1'b0, irq)
      wr(IM, 8'h81);
      wr(CT, 8'h01);
      repeat (3) @(posedge aclk);
      `CHK("irq after clear", 1'b0, irq)
      rd(CT); `CHK("flag cleared", 1'b0, d[7])
      // without match clear the count runs past the compare value
      wr(MD, 8'h00);
      wr16(CL, 16'h0000);
      run_for(8'h05, 60);
      rd16(CL); `CHK("no match clear", 1'b1, w16 > 16'h0010)
      // overflow reload from the pair, then with reload disabled
      for (int en = 1; en >= 0; en--) begin
         wr(CT, 8'h00);
         wr(MD, {en[0], 7'h00});
         wr16(RL, 16'hfff0);
         wr16(CL, 16'hfff0);
         // flag read before the stop write, which would clear it
         wr(CT, 8'h04);
         repeat (60) @(posedge aclk);
         rd(CT); `CHK("overflow flag", 1'b1, d[7])
         wr(CT, 8'h00);
         rd(CL + 8'h01); `CHK("count high after wraps", en ? 8'hff : 8'h00, d)
      end
      // capture triggers per channel, a capture on another channel only copies
      wr(CT, 8'h00);
      wr(IM, 8'h82);
      for (int ch = 0; ch < 3; ch++) begin
         rv = 16'($random(seed));
         cv = 16'($random(seed));
         wr(MD, 8'h80 | 8'(ch + 1));
         wr16(RL, rv);
         wr16(CL, cv);
         pulse(ch);
         repeat (2) @(posedge aclk);
         `CHK("capture irq", 1'b1, irq)
         rd16(CL); `CHK("capture reload", rv, w16)
         rd16(RL); `CHK("captured count", cv, w16)
         pulse((ch + 1) % 3);
         rd16(CL); `CHK("unselected channel", rv, w16)
         rd16(RL); `CHK("second capture", rv, w16)
         wr(IS, 8'h01);
      end
      // capture clear only acts in auto-reload mode
      wr(MD, 8'h08);
      for (int m = 0; m < 2; m++) begin
         wr(CT, 8'(m));
         wr16(CL, cv);
         pulse(0);
         rd16(CL); `CHK("capture clear", m ? cv : 16'h0000, w16)
         rd16(RL); `CHK("capture before clear", cv, w16)
      end
      wrap_up();
   end
endmodule : tb
